//--- hw/alu_exec_pkg.sv
// Purpose: Shared constants and carriers for the instruction execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes: Opcode fields are matched on the upper bits of the word
package alu_exec_pkg;
  localparam int unsigned DATA_W = 8;    // Data path width
  localparam int unsigned ADDR_W = 7;    // File address width
  localparam int unsigned INSN_W = 14;   // Instruction word width
  // Field positions inside the instruction word
  localparam int unsigned DEST_POS = 7;  // Destination select bit
  localparam int unsigned BIT_LO = 7;    // Bit index low position
  localparam int unsigned CLASS_LO = 12; // Two-bit class field
  // Class prefixes
  localparam logic [1:0] CLASS_BYTE = 2'h0; // Byte-oriented file ops
  localparam logic [1:0] CLASS_BIT = 2'h1;  // Bit-oriented file ops
  localparam logic [1:0] CLASS_LIT = 2'h3;  // Literal ops
  // Byte-op codes in bits 11:8
  localparam logic [3:0] OP_ADD_FILE = 4'h7; // Add acc and file
  localparam logic [3:0] OP_AND_FILE = 4'h5; // And acc with file
  localparam logic [3:0] OP_CLR_GRP = 4'h1;  // Clear group (dest bit 1 = file)
  // Bit-op codes in bits 11:10
  localparam logic [1:0] BOP_CLEAR = 2'h0;   // Bit clear
  localparam logic [1:0] BOP_SET = 2'h1;     // Bit set
  localparam logic [1:0] BOP_SKIP0 = 2'h2;   // Skip if bit zero
  localparam logic [1:0] BOP_SKIP1 = 2'h3;   // Skip if bit one
  // Literal codes in bits 11:8, masked to ignore don't-care bits
  localparam logic [3:0] LIT_ADD_VAL = 4'he;  // Add literal, bit 8 ignored
  localparam logic [3:0] LIT_ADD_MASK = 4'he; // Mask for add literal
  localparam logic [3:0] LIT_AND_VAL = 4'h9;  // And literal exact code
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;  // Accumulator after reset
  localparam logic [7:0] ZERO_BYTE = 8'h00;  // Cleared file value

  // Status flags carried together
  typedef struct packed {
    logic carry;       // Carry out of bit 7
    logic nibble_ovf;  // Overflow out of bit 3
    logic zero;        // All-zero result
  } flags_s;

  // File write request
  typedef struct packed {
    logic en;                 // Write strobe
    logic [ADDR_W-1:0] addr;  // Target address
    logic [DATA_W-1:0] data;  // Value written
  } file_wr_s;
endpackage

//--- hw/alu_instruction_exec.sv
// Purpose: Executes add, and, bit set/clear, clear-file and bit-test-skip
// Assumes: Decoder gives one instruction word per valid cycle; file read is combinational
// Notes: Skips flush the following word by turning it into a no-operation
// Functional notes
// - Add literal to accumulator, update three flags
// - Add accumulator and file, update three flags
// - Destination bit zero accumulator, one file
// - And accumulator with file, zero only
// - And literal into accumulator, zero only
// - Bit clear leaves other bits, flags
// - Bit set leaves other bits, flags
// - Skip when bit one, two cycles
// - Skip when bit zero, two cycles
// - Clear file writes zero, sets zero
// - Bit ops use 01 prefix encoding
`timescale 1ns/1ps
`default_nettype none
module alu_instruction_exec (
  input wire logic clock_i,                                    // Core instruction clock
  input wire logic rst_i,                                      // Synchronous reset
  input wire logic insn_valid_i,                               // Instruction word present
  input wire logic [alu_exec_pkg::INSN_W-1:0] insn_i,          // Instruction word
  input wire logic [alu_exec_pkg::DATA_W-1:0] file_rdata_i,    // Addressed file contents
  output logic [alu_exec_pkg::ADDR_W-1:0] file_addr_o,         // File read address
  output alu_exec_pkg::file_wr_s file_wr_o,                    // Registered file write
  output logic [alu_exec_pkg::DATA_W-1:0] acc_o,               // Accumulator
  output alu_exec_pkg::flags_s flags_o,                        // Status flags
  output logic skip_active_o                                   // Current word is discarded
);
  import alu_exec_pkg::*;

  // Decoded fields
  logic [1:0] cls;
  logic [3:0] bop4;
  logic [1:0] bop;
  logic dest;
  logic [2:0] bidx;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] lit;
  logic sel_bit;
  logic do_exec;

  assign cls = insn_i[CLASS_LO +: 2];
  assign bop4 = insn_i[11:8];
  assign bop = insn_i[11:10];
  assign dest = insn_i[DEST_POS];
  assign bidx = insn_i[BIT_LO +: 3];
  assign faddr = insn_i[ADDR_W-1:0];
  assign lit = insn_i[DATA_W-1:0];
  assign file_addr_o = faddr;
  assign sel_bit = file_rdata_i[bidx];

  // State
  logic [DATA_W-1:0] acc_q;
  flags_s flags_q;
  file_wr_s wr_q;
  logic skip_q;

  // A skipped word executes as a no-operation
  assign do_exec = insn_valid_i && !skip_q;

  // Combinational execute results
  logic [DATA_W-1:0] res;
  logic res_to_acc;
  logic res_to_file;
  logic upd_arith;
  logic upd_zero;
  logic force_zero;
  logic skip_d;
  logic [DATA_W:0] sum9;
  logic [4:0] sum5;
  logic [DATA_W-1:0] add_b;

  // Add operand picks literal or file value
  always_comb begin
    add_b = (cls == CLASS_LIT) ? lit : file_rdata_i;
    sum9 = {1'b0, acc_q} + {1'b0, add_b};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, add_b[3:0]};
  end

  // Instruction decode and result select
  always_comb begin
    res = ZERO_BYTE;
    res_to_acc = 1'b0;
    res_to_file = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    force_zero = 1'b0;
    skip_d = 1'b0;
    if (do_exec) begin
      unique case (cls)
        CLASS_BYTE: begin
          if (bop4 == OP_ADD_FILE) begin
            res = sum9[DATA_W-1:0];
            res_to_acc = !dest;
            res_to_file = dest;
            upd_arith = 1'b1;
          end else if (bop4 == OP_AND_FILE) begin
            res = acc_q & file_rdata_i;
            res_to_acc = !dest;
            res_to_file = dest;
            upd_zero = 1'b1;
          end else if (bop4 == OP_CLR_GRP && dest) begin
            res = ZERO_BYTE;
            res_to_file = 1'b1;
            force_zero = 1'b1;
          end else begin
            // Other byte ops handled elsewhere
            res = ZERO_BYTE;
          end
        end
        CLASS_BIT: begin
          // Bit ops: 01 prefix then two-bit code
          unique case (bop)
            BOP_CLEAR: begin
              res = file_rdata_i & ~(8'h01 << bidx);
              res_to_file = 1'b1;
            end
            BOP_SET: begin
              res = file_rdata_i | (8'h01 << bidx);
              res_to_file = 1'b1;
            end
            BOP_SKIP0: skip_d = !sel_bit;
            BOP_SKIP1: skip_d = sel_bit;
          endcase
        end
        CLASS_LIT: begin
          if ((bop4 & LIT_ADD_MASK) == LIT_ADD_VAL) begin
            res = sum9[DATA_W-1:0];
            res_to_acc = 1'b1;
            upd_arith = 1'b1;
          end else if (bop4 == LIT_AND_VAL) begin
            res = acc_q & lit;
            res_to_acc = 1'b1;
            upd_zero = 1'b1;
          end else begin
            // Other literal ops handled elsewhere
            res = ZERO_BYTE;
          end
        end
        default: begin
          // Branch class belongs to the sequencer
          res = ZERO_BYTE;
        end
      endcase
    end
  end

  // Accumulator update
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_q <= ACC_RESET;
    end else if (res_to_acc) begin
      acc_q <= res;
    end
  end

  // Flag update; bit ops never reach here
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else if (upd_arith) begin
      flags_q.carry <= sum9[DATA_W];
      flags_q.nibble_ovf <= sum5[4];
      flags_q.zero <= (res == ZERO_BYTE);
    end else if (upd_zero) begin
      flags_q.zero <= (res == ZERO_BYTE);
    end else if (force_zero) begin
      flags_q.zero <= 1'b1;
    end
  end

  // Registered file write, one cycle strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_q <= '0;
    end else begin
      wr_q.en <= res_to_file;
      wr_q.addr <= faddr;
      wr_q.data <= res;
    end
  end

  // Skip marker kills exactly the next valid word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      skip_q <= 1'b0;
    end else if (skip_d) begin
      skip_q <= 1'b1;
    end else if (insn_valid_i) begin
      skip_q <= 1'b0;
    end
  end

  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign file_wr_o = wr_q;
  assign skip_active_o = skip_q;

  // Assertions
  property p_add_lit;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_LIT && bop4[3:1] == 3'h7)
      |=> (acc_q == $past(acc_q) + $past(lit))
          && (flags_q.carry == ((9'h000 + $past(acc_q) + $past(lit)) > 9'h0ff))
          && (flags_q.nibble_ovf == ((5'h00 + $past(acc_q[3:0]) + $past(lit[3:0])) > 5'h0f))
          && (flags_q.zero == (acc_q == 8'h00));
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

  property p_dest_file;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BYTE && bop4 == OP_ADD_FILE && dest)
      |=> file_wr_o.en && $stable(acc_q) && file_wr_o.data == $past(acc_q) + $past(file_rdata_i);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest file wrong");

  property p_add_file_acc;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BYTE && bop4 == OP_ADD_FILE && !dest)
      |=> !file_wr_o.en && acc_q == $past(acc_q) + $past(file_rdata_i);
  endproperty
  a_add_file_acc: assert property (p_add_file_acc) else $error("add file wrong");

  property p_and_file;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BYTE && bop4 == OP_AND_FILE)
      |=> $stable(flags_q.carry) && $stable(flags_q.nibble_ovf)
          && flags_q.zero == ($past(acc_q & file_rdata_i) == 8'h00);
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file flags wrong");

  property p_and_lit;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_LIT && bop4 == LIT_AND_VAL)
      |=> acc_q == ($past(acc_q) & $past(lit)) && $stable(flags_q.carry);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

  property p_bit_clr;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && bop == BOP_CLEAR)
      |=> file_wr_o.en && !file_wr_o.data[$past(bidx)] && $stable(flags_q);
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

  property p_bit_set;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && bop == BOP_SET)
      |=> file_wr_o.en && file_wr_o.data[$past(bidx)] && $stable(flags_q);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_skip1;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && bop == BOP_SKIP1 && sel_bit) |=> skip_q;
  endproperty
  a_skip1: assert property (p_skip1) else $error("skip on one missed");

  property p_skip0;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && bop == BOP_SKIP0) |=> (skip_q == !$past(sel_bit));
  endproperty
  a_skip0: assert property (p_skip0) else $error("skip on zero wrong");

  property p_file_zero_op;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BYTE && bop4 == OP_CLR_GRP && dest)
      |=> flags_q.zero && file_wr_o.en && file_wr_o.data == 8'h00;
  endproperty
  a_file_zero_op: assert property (p_file_zero_op) else $error("clear file wrong");

  property p_skip_nop;
    @(posedge clock_i) disable iff (rst_i)
    (skip_q && insn_valid_i) |=> $stable(acc_q) && !file_wr_o.en;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped word executed");

  property p_skip_hold;
    @(posedge clock_i) disable iff (rst_i)
    (skip_q && !insn_valid_i) |=> skip_q;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("discard lost");

  property p_test_quiet;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && bop[1])
      |=> $stable(flags_q) && $stable(acc_q) && !file_wr_o.en;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("test changed state");

  property p_bit_keep;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BIT && !bop[1])
      |=> ((file_wr_o.data ^ $past(file_rdata_i)) & ~(8'h01 << $past(bidx))) == 8'h00;
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("other bits touched");

  property p_and_dest;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_BYTE && bop4 == OP_AND_FILE && dest)
      |=> file_wr_o.en && $stable(acc_q)
          && file_wr_o.data == ($past(acc_q) & $past(file_rdata_i));
  endproperty
  a_and_dest: assert property (p_and_dest) else $error("and dest wrong");

  property p_lit_no_file;
    @(posedge clock_i) disable iff (rst_i)
    (do_exec && cls == CLASS_LIT) |=> !file_wr_o.en;
  endproperty
  a_lit_no_file: assert property (p_lit_no_file) else $error("literal wrote file");
endmodule // alu_instruction_exec
`default_nettype wire

//--- tb/test_alu_instruction_exec.sv
// Purpose: Self-checking bench for the instruction execute block
// Assumes: Bench acts as the file register array with a same-cycle read
// Notes: Expected values come from a small reference model kept in the bench
`timescale 1ns/1ps
`default_nettype none
module test_alu_instruction_exec;
  import alu_exec_pkg::*;
  logic clock_i = 1'b0; // Core clock
  logic rst_i = 1'b1; // Held high at start
  logic insn_valid_i = 1'b0; // Word present
  logic [INSN_W-1:0] insn_i = 14'h0000; // Word driven
  logic [DATA_W-1:0] file_rdata_i; // Read data back to block
  logic [ADDR_W-1:0] file_addr_o; // Read address from block
  file_wr_s file_wr_o; // Write request from block
  logic [DATA_W-1:0] acc_o; // Accumulator seen
  flags_s flags_o; // Flags seen
  logic skip_active_o; // Discard pending
  logic [7:0] mem [128]; // Bench file array
  logic [7:0] mem_e [128]; // Expected file contents
  logic [7:0] acc_e; // Expected accumulator
  flags_s flg_e; // Expected flags
  logic skip_e; // Expected discard state
  int err_total = 0; // Mismatches
  int cmp_count = 0; // Comparisons

  alu_instruction_exec i_alu_instruction_exec (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .insn_valid_i(insn_valid_i),
    .insn_i(insn_i),
    .file_rdata_i(file_rdata_i),
    .file_addr_o(file_addr_o),
    .file_wr_o(file_wr_o),
    .acc_o(acc_o),
    .flags_o(flags_o),
    .skip_active_o(skip_active_o)
  );

  // Free-running clock
  always #5 clock_i = ~clock_i;
  // Forward a pending write, since the block does not forward its own writes
  assign file_rdata_i = (file_wr_o.en === 1'b1 && file_wr_o.addr === file_addr_o) ?
                        file_wr_o.data : mem[file_addr_o];
  // File array takes the registered write
  always @(posedge clock_i) begin
    if (file_wr_o.en === 1'b1) begin
      mem[file_wr_o.addr] <= file_wr_o.data;
    end
  end

  // One comparison, counted
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Every registered output but the write address and data back at its reset value
  task automatic chk_rst;
    chk("rst_acc", {8'h00, ACC_RESET}, {8'h00, acc_o});
    chk("rst_flags", 16'h0000, {13'h0000, flags_o});
    chk("rst_skip", 16'h0000, {15'h0000, skip_active_o});
    chk("rst_wr_en", 16'h0000, {15'h0000, file_wr_o.en});
  endtask

  // Predict, issue one word for one cycle, then compare every output, write address and data only when a write is expected
  task automatic run(input logic [13:0] w);
    logic [7:0] f;
    logic [7:0] opnd;
    logic [8:0] s;
    logic [7:0] r;
    logic wr;
    f = mem_e[w[6:0]];
    opnd = w[13] ? w[7:0] : f;
    r = 8'h00;
    wr = 1'b0;
    if (skip_e) begin
      skip_e = 1'b0; // Discarded word acts as no-operation
    end else begin
      casez (w)
        14'b11111z????????, 14'b000111????????: begin
          s = {1'b0, acc_e} + {1'b0, opnd};
          r = s[7:0];
          flg_e.carry = s[8];
          flg_e.nibble_ovf = ({1'b0, acc_e[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
          flg_e.zero = (r == 8'h00);
          wr = !w[13] && w[7];
          if (!wr) acc_e = r;
        end
        14'b111001????????, 14'b000101????????: begin
          r = acc_e & opnd;
          flg_e.zero = (r == 8'h00);
          wr = !w[13] && w[7];
          if (!wr) acc_e = r;
        end
        14'b0000011???????: begin
          wr = 1'b1;
          flg_e.zero = 1'b1;
        end
        14'b0100??????????: begin
          r = f & ~(8'h01 << w[9:7]);
          wr = 1'b1;
        end
        14'b0101??????????: begin
          r = f | (8'h01 << w[9:7]);
          wr = 1'b1;
        end
        14'b0110??????????: skip_e = ~f[w[9:7]];
        14'b0111??????????: skip_e = f[w[9:7]];
        default: ;
      endcase
      if (wr) mem_e[w[6:0]] = r;
    end
    insn_i = w;
    insn_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    chk("acc", {8'h00, acc_e}, {8'h00, acc_o});
    chk("flags", {13'h0000, flg_e}, {13'h0000, flags_o});
    chk("skip", {15'h0000, skip_e}, {15'h0000, skip_active_o});
    chk("wr_en", {15'h0000, wr}, {15'h0000, file_wr_o.en});
    chk("file_addr", {9'h000, w[6:0]}, {9'h000, file_addr_o});
    if (wr) begin
      chk("wr_addr_data", {1'b0, w[6:0], r}, {1'b0, file_wr_o.addr, file_wr_o.data});
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Guard against a hang
  initial begin
    #200000;
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 7 + 5);
      mem_e[i] = 8'(i * 7 + 5);
    end
    acc_e = ACC_RESET;
    flg_e = 3'h0;
    skip_e = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk_rst();
    // Literal ops, both forms of the ignored code bit, carry and nibble boundaries
    run(14'h3eff);
    run(14'h3f01);
    run(14'h39ff);
    run(14'h3e0f);
    run(14'h3e01);
    run(14'h3930);
    run(14'h39ef);
    $display("literal ops done");
    // File ops with both destinations, back to back on one address
    run(14'h3e80);
    run(14'h077f);
    run(14'h0785);
    run(14'h0705);
    run(14'h0510);
    run(14'h05a0);
    run(14'h01ff);
    run(14'h077f);
    $display("file ops done");
    // Every bit index set, then even ones cleared
    for (int b = 0; b < 8; b++) run({2'h1, BOP_SET, 3'(b), 7'h40});
    for (int b = 0; b < 8; b += 2) run({2'h1, BOP_CLEAR, 3'(b), 7'h40});
    $display("bit ops done");
    // Both tests on every bit, followed at once by a word that may be discarded
    for (int b = 0; b < 8; b++) begin
      run({2'h1, BOP_SKIP0, 3'(b), 7'h40});
      run(14'h3e11);
      run({2'h1, BOP_SKIP1, 3'(b), 7'h40});
      run(14'h3e23);
    end
    $display("skip ops done");
    // Unhandled codes leave every register but the write address and data alone
    run(14'h0100);
    run(14'h2abc);
    run(14'h3855);
    // A pending discard waits through an idle cycle, then reset drops it
    run({2'h1, BOP_SKIP1, 3'h1, 7'h40});
    insn_valid_i = 1'b0;
    @(posedge clock_i);
    #1;
    chk("skip_hold", 16'h0001, {15'h0000, skip_active_o});
    rst_i = 1'b1;
    @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    acc_e = ACC_RESET;
    flg_e = 3'h0;
    skip_e = 1'b0;
    chk_rst();
    run(14'h3e11);
    insn_valid_i = 1'b0;
    $display("reset and idle done");
    test_done();
  end
endmodule // test_alu_instruction_exec
`default_nettype wire
